// *** logic/umcbg_pkg.sv ***
// Purpose: Shared constants for the modem handshake and baud divider block
// Assumes: Byte-wide parallel register port, three address lines
// Notes:   Offsets select registers on the channel's own address lines
package umcbg_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int DIV_W  = 16;

  // ==========================================================
  // Register offsets on the channel address lines
  localparam logic [ADDR_W-1:0] OFS_DIV_LO = 3'h0;  // Divisor low byte, divisor access set
  localparam logic [ADDR_W-1:0] OFS_DIV_HI = 3'h1;  // Divisor high byte, divisor access set
  localparam logic [ADDR_W-1:0] OFS_CTL    = 3'h4;  // handshake_ctl_reg
  localparam logic [ADDR_W-1:0] OFS_STAT   = 3'h6;  // handshake_stat_reg

  // ==========================================================
  // Control register fields
  localparam int CTL_W          = 5;  // Bits above read as zero
  localparam int CTL_TERM_READY = 0;
  localparam int CTL_REQ_SEND   = 1;
  localparam int CTL_USER_A     = 2;
  localparam int CTL_USER_B     = 3;  // Also gates the channel interrupt pin
  localparam int CTL_LOOP       = 4;
  localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;

  // ==========================================================
  // Modem line index, same order in the delta and level halves
  localparam int MDM_N    = 4;
  localparam int MDM_CTS  = 0;
  localparam int MDM_DSR  = 1;
  localparam int MDM_RING = 2;
  localparam int MDM_DCD  = 3;
  localparam logic [MDM_N-1:0] MDM_CLEAR = 4'h0;

  // ==========================================================
  // Baud divider reset and terminal count
  localparam logic [DATA_W-1:0] DIV_LO_RESET = 8'h01;
  localparam logic [DATA_W-1:0] DIV_HI_RESET = 8'h00;
  localparam logic [DIV_W-1:0]  COUNT_LAST   = 16'h0001;
  localparam logic [DIV_W-1:0]  COUNT_RESET  = 16'h0000;
  localparam logic [DIV_W-1:0]  DIV_NONE     = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO    = 8'h00;

endpackage

// *** logic/umcbg_modem_ctrl.sv ***
// Purpose: Modem control, modem status and baud divider of one serial channel
// Assumes: All inputs synchronous to clock; strobes sampled once per clock
// Notes:   Status read trailing edge is the first cycle the read strobe is seen high
//
// How it works
// - Control bit 0 set drives terminal_ready_n low, clear drives it high.
// - Control bit 1 set drives request_send_n low, clear drives it high.
// - Control bit 2 set drives user_output_a_n low, clear drives it high.
// - Control bit 3 gates the channel interrupt onto its output pin.
// - Loop-back holds serial output high and feeds transmitter into receiver.
// - Loop-back ignores modem pins, routes control bits inward, outputs go high.
// - Loop-back modem events come only from control bit writes, never pins.
// - Control bits 5 to 7 always read zero.
// - Status bits 4 to 7 read one when their modem input pin is low.
// - Status bits 0, 1, 3 set on any change of their input.
// - Status bit 2 sets only on ring input rising from low to high.
// - Reading status clears the four change bits, leaving the level bits.
// - With modem interrupt enabled, any change bit raises the modem interrupt.
// - In loop-back, level bits show request, ready, user A, user B.
// - Changes during a status read set their bit only at read end.
// - A set bit whose change recurs during the read clears at read end.
// - Baud divider divides clock by 1 to 65535, giving the 16x tick.
// - Divisor is sixteen bits held in two byte latches, both loaded by software.
// - Writing either divisor latch reloads the baud counter at once.
// - Reset clears all control bits, so handshake outputs go high.
// - Reset clears change bits; level bits keep following the pins.
`timescale 1ns/10ps
module umcbg_modem_ctrl
  import umcbg_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  // Clock, reset and enable
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  // Parallel register port
  input  wire logic                chip_sel_n,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   wr_data,
  input  wire logic                read_strobe_n,
  input  wire logic                write_strobe_n,
  input  wire logic                divisor_access,
  output logic      [DATA_W-1:0]   rd_data,
  // Modem input pins
  input  wire logic                clear_to_send_n,
  input  wire logic                set_ready_n,
  input  wire logic                ring_in_n,
  input  wire logic                carrier_detect_in_n,
  // Modem output pins
  output logic                     terminal_ready_n,
  output logic                     request_send_n,
  output logic                     user_output_a_n,
  output logic                     user_output_b_n,
  // Serial data path
  input  wire logic                serial_rx_pin,
  output logic                     serial_tx_pin,
  input  wire logic                tx_shift_out,
  output logic                     rx_shift_in,
  // Interrupts
  input  wire logic                modem_irq_enable,
  input  wire logic                core_irq,
  output logic                     modem_irq,
  output logic                     serial_irq,
  // Baud divider
  output logic                     sample_tick,
  output logic      [DIV_WIDTH-1:0] divisor
);

  // ==========================================================
  // Elaboration checks
  if (DIV_WIDTH != DIV_W) begin : g_bad_width
    $error("divisor width must equal two byte latches");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [CTL_W-1:0]     ctl;
    logic [MDM_N-1:0]     level;
    logic                 primed;
    logic [MDM_N-1:0]     delta;
    logic [MDM_N-1:0]     pend;
    logic                 stat_rd;
    logic [DATA_W-1:0]    div_lo;
    logic [DATA_W-1:0]    div_hi;
    logic [DIV_WIDTH-1:0] count;
    logic                 tick;
    logic [DATA_W-1:0]    rd_data;
  } umcbg_state_t;

  umcbg_state_t state_reg;
  umcbg_state_t state_next;

  // Joins the two divisor latches
  function automatic logic [DIV_WIDTH-1:0] join_div(input logic [DATA_W-1:0] lo,
                                                    input logic [DATA_W-1:0] hi);
    join_div = {hi, lo};
  endfunction

  // ==========================================================
  // Decode of the register port
  logic             access;
  logic             rd_any;
  logic             wr_any;
  logic             stat_rd_now;
  logic             stat_rd_end;
  logic             wr_ctl;
  logic             wr_lo;
  logic             wr_hi;
  logic             loop_on;
  logic [MDM_N-1:0] eff_level;
  logic [MDM_N-1:0] events;

  // Strobes qualified by chip select
  assign access      = ~chip_sel_n;
  assign rd_any      = access & ~read_strobe_n;
  assign wr_any      = access & ~write_strobe_n & read_strobe_n;
  assign stat_rd_now = rd_any & (reg_addr == OFS_STAT);
  assign stat_rd_end = state_reg.stat_rd & ~stat_rd_now;
  // Status register has no write path
  assign wr_ctl      = wr_any & (reg_addr == OFS_CTL);
  assign wr_lo       = wr_any & divisor_access & (reg_addr == OFS_DIV_LO);
  assign wr_hi       = wr_any & divisor_access & (reg_addr == OFS_DIV_HI);
  assign loop_on     = state_reg.ctl[CTL_LOOP];

  // Effective modem levels, one means asserted
  always_comb begin
    if (loop_on) begin
      // Pins ignored, control bits looped inward
      eff_level[MDM_CTS]  = state_reg.ctl[CTL_REQ_SEND];
      eff_level[MDM_DSR]  = state_reg.ctl[CTL_TERM_READY];
      eff_level[MDM_RING] = state_reg.ctl[CTL_USER_A];
      eff_level[MDM_DCD]  = state_reg.ctl[CTL_USER_B];
    end else begin
      // Inverted pin levels
      eff_level[MDM_CTS]  = ~clear_to_send_n;
      eff_level[MDM_DSR]  = ~set_ready_n;
      eff_level[MDM_RING] = ~ring_in_n;
      eff_level[MDM_DCD]  = ~carrier_detect_in_n;
    end
  end

  // Change events against the previous level, after first sample
  always_comb begin
    events = MDM_CLEAR;
    if (state_reg.primed) begin
      events[MDM_CTS] = state_reg.level[MDM_CTS] ^ eff_level[MDM_CTS];
      events[MDM_DSR] = state_reg.level[MDM_DSR] ^ eff_level[MDM_DSR];
      events[MDM_DCD] = state_reg.level[MDM_DCD] ^ eff_level[MDM_DCD];
      // Pin rising means level bit falling
      events[MDM_RING] = state_reg.level[MDM_RING] & ~eff_level[MDM_RING];
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next         = state_reg;
    state_next.level   = eff_level;
    state_next.primed  = 1'b1;
    state_next.stat_rd = stat_rd_now;

    // Control register write, upper bits not stored
    if (wr_ctl) begin
      state_next.ctl = wr_data[CTL_W-1:0];
    end

    // Change bits: hold during a status read, settle at its end
    if (stat_rd_now) begin
      state_next.pend = state_reg.pend | events;
    end else if (stat_rd_end) begin
      // Read clears; recurring set bits clear, new ones set
      state_next.delta = (state_reg.pend | events) & ~state_reg.delta;
      state_next.pend  = MDM_CLEAR;
    end else begin
      state_next.delta = state_reg.delta | events;
    end

    // Read data captured while the strobe is low
    if (rd_any) begin
      state_next.rd_data = DATA_ZERO;
      if (divisor_access && reg_addr == OFS_DIV_LO) begin
        state_next.rd_data = state_reg.div_lo;
      end else if (divisor_access && reg_addr == OFS_DIV_HI) begin
        state_next.rd_data = state_reg.div_hi;
      end else if (reg_addr == OFS_CTL) begin
        state_next.rd_data = {{(DATA_W-CTL_W){1'b0}}, state_reg.ctl};
      end else if (reg_addr == OFS_STAT) begin
        state_next.rd_data = {eff_level, state_reg.delta};
      end
    end

    // Divisor latches
    if (wr_lo) begin
      state_next.div_lo = wr_data;
    end
    if (wr_hi) begin
      state_next.div_hi = wr_data;
    end

    // Baud counter
    state_next.tick = 1'b0;
    if (wr_lo || wr_hi) begin
      // Immediate reload avoids a long first count
      state_next.count = join_div(state_next.div_lo, state_next.div_hi);
    end else if (divisor == DIV_NONE) begin
      state_next.count = COUNT_RESET; // Zero divisor stops the tick
    end else if (state_reg.count <= COUNT_LAST) begin
      state_next.tick  = 1'b1;
      state_next.count = divisor;
    end else begin
      state_next.count = state_reg.count - COUNT_LAST;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg.ctl     <= CTL_RESET;
      state_reg.level   <= MDM_CLEAR;
      state_reg.primed  <= 1'b0;
      state_reg.delta   <= MDM_CLEAR;
      state_reg.pend    <= MDM_CLEAR;
      state_reg.stat_rd <= 1'b0;
      state_reg.div_lo  <= DIV_LO_RESET;
      state_reg.div_hi  <= DIV_HI_RESET;
      state_reg.count   <= COUNT_RESET;
      state_reg.tick    <= 1'b0;
      state_reg.rd_data <= DATA_ZERO;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign divisor     = join_div(state_reg.div_lo, state_reg.div_hi);
  assign sample_tick = state_reg.tick;
  assign rd_data     = state_reg.rd_data;

  // Handshake outputs, inverted control bits, high in loop-back
  assign terminal_ready_n = loop_on | ~state_reg.ctl[CTL_TERM_READY];
  assign request_send_n   = loop_on | ~state_reg.ctl[CTL_REQ_SEND];
  assign user_output_a_n  = loop_on | ~state_reg.ctl[CTL_USER_A];
  assign user_output_b_n  = loop_on | ~state_reg.ctl[CTL_USER_B];

  // Serial path, marking high and internal loop in loop-back
  assign serial_tx_pin = loop_on | tx_shift_out;
  assign rx_shift_in   = loop_on ? tx_shift_out : serial_rx_pin;

  // Modem status interrupt and gated channel interrupt pin
  assign modem_irq  = modem_irq_enable & (|state_reg.delta);
  assign serial_irq = state_reg.ctl[CTL_USER_B] & (core_irq | modem_irq);

endmodule

// *** tb/umcbg_modem_ctrl_monitor.sv ***
// Purpose: Port checker for the modem handshake and baud block
// Assumes: clk_en held high by the bench
// Notes:   Bound to umcbg_modem_ctrl below
`timescale 1ns/10ps
module umcbg_modem_ctrl_monitor
  import umcbg_pkg::*;
#(
  parameter int DIV_WIDTH = DIV_W
) (
  // Clock and register port
  input wire logic                 clock,
  input wire logic                 resetn,
  input wire logic                 clk_en,
  input wire logic                 chip_sel_n,
  input wire logic [ADDR_W-1:0]    reg_addr,
  input wire logic [DATA_W-1:0]    wr_data,
  input wire logic                 read_strobe_n,
  input wire logic                 write_strobe_n,
  input wire logic                 divisor_access,
  input wire logic [DATA_W-1:0]    rd_data,
  // Pins and interrupts
  input wire logic                 terminal_ready_n,
  input wire logic                 request_send_n,
  input wire logic                 user_output_a_n,
  input wire logic                 user_output_b_n,
  input wire logic                 serial_tx_pin,
  input wire logic                 core_irq,
  input wire logic                 modem_irq_enable,
  input wire logic                 modem_irq,
  input wire logic                 serial_irq,
  // Baud divider
  input wire logic                 sample_tick,
  input wire logic [DIV_WIDTH-1:0] divisor
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Decoded bus cycles
  logic wr_ok;
  logic ctl_wr;
  logic lo_wr;
  assign wr_ok  = clk_en && !chip_sel_n && !write_strobe_n && read_strobe_n;
  assign ctl_wr = wr_ok && reg_addr == OFS_CTL;
  assign lo_wr  = wr_ok && reg_addr == OFS_DIV_LO;

  // ==========================================================
  // Properties
  a_ready_request: assert property (ctl_wr && !wr_data[CTL_LOOP] |=>
    terminal_ready_n == !$past(wr_data[CTL_TERM_READY]) &&
    request_send_n == !$past(wr_data[CTL_REQ_SEND])) else $error("handshake pin wrong");
  a_loop_pins_high: assert property (ctl_wr && wr_data[CTL_LOOP] |=>
    terminal_ready_n && request_send_n && user_output_a_n && user_output_b_n)
    else $error("loop pins not high");
  a_loop_tx_mark: assert property (ctl_wr && wr_data[CTL_LOOP] |=> serial_tx_pin)
    else $error("loop tx not marking");
  a_ctl_upper_zero: assert property (clk_en && !chip_sel_n && !read_strobe_n &&
    reg_addr == OFS_CTL |=> rd_data[7:5] == 3'h0) else $error("ctl upper bits set");
  a_irq_gate_off: assert property (ctl_wr && !wr_data[CTL_USER_B] |=> !serial_irq)
    else $error("irq pin not gated");
  a_irq_gate_src: assert property (serial_irq |-> core_irq || modem_irq)
    else $error("irq pin without source");
  a_modem_irq_en: assert property (!modem_irq_enable |-> !modem_irq)
    else $error("modem irq while disabled");
  a_div_latch: assert property (lo_wr && divisor_access |=>
    divisor[7:0] == $past(wr_data)) else $error("divisor low not latched");
  a_div_refused: assert property (lo_wr && !divisor_access |=> $stable(divisor))
    else $error("divisor changed without access");
  a_tick_every: assert property (sample_tick && divisor == 16'h0001 && clk_en &&
    write_strobe_n |=> sample_tick) else $error("divide by one missed tick");
  a_tick_period: assert property (sample_tick && divisor == 16'h0003 && write_strobe_n
    ##1 (clk_en && write_strobe_n && divisor == 16'h0003) [*3] |-> sample_tick)
    else $error("divide by three period wrong");

  // Main scenarios reached
  c_loop: cover property (ctl_wr && wr_data[CTL_LOOP]);
  c_irq_clear: cover property (modem_irq ##1 !modem_irq);
  c_tick3: cover property (sample_tick && divisor == 16'h0003);
endmodule

bind umcbg_modem_ctrl umcbg_modem_ctrl_monitor #(.DIV_WIDTH(DIV_WIDTH)) u_mon (.clock,
  .resetn, .clk_en, .chip_sel_n, .reg_addr, .wr_data, .read_strobe_n, .write_strobe_n,
  .divisor_access, .rd_data, .terminal_ready_n, .request_send_n, .user_output_a_n,
  .user_output_b_n, .serial_tx_pin, .core_irq, .modem_irq_enable, .modem_irq, .serial_irq,
  .sample_tick, .divisor);

// *** tb/umcbg_modem_peer.sv ***
// Purpose: Modem model driving the four handshake input pins
// Assumes: line_on bit set means the line is asserted
// Notes:   slow adds one cycle of lag
`timescale 1ns/10ps
module umcbg_modem_peer
  import umcbg_pkg::*;
(
  // Control from the bench
  input wire logic             clock,
  input wire logic [MDM_N-1:0] line_on,
  input wire logic             slow,
  // Modem pins, active low
  output logic                 clear_to_send_n,
  output logic                 set_ready_n,
  output logic                 ring_in_n,
  output logic                 carrier_detect_in_n
);
  logic [MDM_N-1:0] lag_reg;
  // One cycle lag stage
  always @(posedge clock) lag_reg <= line_on;
  // Pins low while asserted
  assign {carrier_detect_in_n, ring_in_n, set_ready_n, clear_to_send_n} =
    ~(slow ? lag_reg : line_on);
endmodule

// *** tb/umcbg_modem_ctrl_bench.sv ***
// Purpose: Self-checking bench for the modem handshake and baud block
// Assumes: clk_en held high throughout
// Notes:   One task per scenario
`timescale 1ns/10ps
module umcbg_modem_ctrl_bench
  import umcbg_pkg::*;
;
  logic clock, resetn, clk_en, chip_sel_n, read_strobe_n, write_strobe_n, divisor_access;
  logic clear_to_send_n, set_ready_n, ring_in_n, carrier_detect_in_n, slow, sample_tick;
  logic terminal_ready_n, request_send_n, user_output_a_n, user_output_b_n;
  logic serial_rx_pin, serial_tx_pin, tx_shift_out, rx_shift_in;
  logic modem_irq_enable, core_irq, modem_irq, serial_irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] wr_data, rd_data, got;
  logic [DIV_W-1:0] divisor;
  logic [MDM_N-1:0] line_on;
  int n_fail, num_checks, ticks;

  // ==========================================================
  // Clock, design and modem
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  umcbg_modem_ctrl #(.DIV_WIDTH(DIV_W)) dut (.clock, .resetn, .clk_en, .chip_sel_n, .reg_addr,
    .wr_data, .read_strobe_n, .write_strobe_n, .divisor_access, .rd_data, .clear_to_send_n,
    .set_ready_n, .ring_in_n, .carrier_detect_in_n, .terminal_ready_n, .request_send_n,
    .user_output_a_n, .user_output_b_n, .serial_rx_pin, .serial_tx_pin, .tx_shift_out,
    .rx_shift_in, .modem_irq_enable, .core_irq, .modem_irq, .serial_irq, .sample_tick, .divisor);
  umcbg_modem_peer peer (.clock, .line_on, .slow, .clear_to_send_n, .set_ready_n, .ring_in_n,
    .carrier_detect_in_n);

  // ==========================================================
  // Shared tasks
  function automatic logic [7:0] pins();
    return {4'h0, terminal_ready_n, request_send_n, user_output_a_n, user_output_b_n};
  endfunction
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock);
    chip_sel_n <= 1'b0;
    reg_addr <= a;
    wr_data <= d;
    write_strobe_n <= 1'b0;
    @(posedge clock);
    chip_sel_n <= 1'b1;
    write_strobe_n <= 1'b1;
  endtask
  task automatic rd(logic [2:0] a, int hold);
    @(posedge clock);
    chip_sel_n <= 1'b0;
    reg_addr <= a;
    read_strobe_n <= 1'b0;
    repeat (hold + 1) @(posedge clock);
    #1 got = rd_data;
    @(posedge clock);
    chip_sel_n <= 1'b1;
    read_strobe_n <= 1'b1;
  endtask
  task automatic stat(logic [7:0] exp);
    repeat (4) @(posedge clock);
    rd(OFS_STAT, 0); // status only ever read, never written
    chk("status", exp, got);
  endtask
  task automatic count(int n, int exp);
    ticks = 0;
    repeat (n) begin
      @(posedge clock);
      #1 ticks += int'(sample_tick);
    end
    chk("ticks", exp[7:0], ticks[7:0]);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    @(posedge clock);
    #1 chk("pins", 8'h0f, pins());
    stat(8'h00);
    rd(OFS_CTL, 0);
    chk("ctl", 8'h00, got);
    $display("test reset done");
  endtask
  task automatic t_ctl;
    core_irq <= 1'b1;
    wr(OFS_CTL, 8'he5);
    rd(OFS_CTL, 0);
    chk("ctl", 8'h05, got);
    chk("pins", 8'h05, pins());
    wr(OFS_CTL, 8'h0a);
    @(posedge clock);
    #1 chk("pins", 8'h0a, pins());
    chk("irq_pin", 8'h01, {7'h0, serial_irq});
    wr(OFS_CTL, 8'h02);
    @(posedge clock);
    #1 chk("irq_pin", 8'h00, {7'h0, serial_irq});
    $display("test control done");
  endtask
  task automatic t_loop;
    modem_irq_enable <= 1'b1;
    tx_shift_out <= 1'b0;
    wr(OFS_CTL, 8'h1b);
    @(posedge clock);
    #1 chk("pins", 8'h0f, pins());
    chk("tx_rx", 8'h10, {3'h0, serial_tx_pin, 3'h0, rx_shift_in});
    rd(OFS_STAT, 0);
    stat(8'hb0);
    line_on <= 4'hf;
    stat(8'hb0);
    wr(OFS_CTL, 8'h1a);
    @(posedge clock);
    #1 chk("modem_irq", 8'h01, {7'h0, modem_irq});
    stat(8'h92);
    wr(OFS_CTL, 8'h08);
    line_on <= 4'h0;
    stat(8'h09);
    stat(8'h00);
    $display("test loop done");
  endtask
  task automatic t_status;
    slow <= 1'b1;
    line_on <= 4'h1;
    repeat (4) @(posedge clock);
    #1 chk("modem_irq", 8'h01, {7'h0, modem_irq});
    stat(8'h11);
    stat(8'h10);
    line_on <= 4'h5;
    stat(8'h50);
    line_on <= 4'h1;
    stat(8'h14);
    line_on <= 4'hb;
    stat(8'hba);
    line_on <= 4'h0;
    stat(8'h0b);
    slow <= 1'b0;
    $display("test status done");
  endtask
  task automatic t_inhibit;
    fork
      rd(OFS_STAT, 6);
      begin
        repeat (3) @(posedge clock);
        line_on <= 4'h1;
      end
    join
    chk("in_read", 8'h10, got);
    stat(8'h11);
    repeat (2) @(posedge clock);
    line_on <= 4'h0;
    repeat (3) @(posedge clock);
    fork
      rd(OFS_STAT, 6);
      begin
        repeat (3) @(posedge clock);
        line_on <= 4'h1;
      end
    join
    stat(8'h10);
    $display("test inhibit done");
  endtask
  task automatic t_baud;
    divisor_access <= 1'b1;
    wr(OFS_DIV_HI, 8'h01);
    wr(OFS_DIV_LO, 8'h03);
    @(posedge clock);
    #1 chk("div_hi", 8'h01, divisor[15:8]);
    wr(OFS_DIV_HI, 8'h00);
    count(5, 1);
    count(30, 10);
    wr(OFS_DIV_LO, 8'h01);
    repeat (2) @(posedge clock);
    count(10, 10);
    divisor_access <= 1'b0;
    wr(OFS_DIV_LO, 8'h07);
    @(posedge clock);
    #1 chk("div_lo", 8'h01, divisor[7:0]);
    $display("test baud done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    n_fail = 0;
    num_checks = 0;
    {resetn, chip_sel_n, read_strobe_n, write_strobe_n, clk_en} = 5'b01111;
    {divisor_access, modem_irq_enable, core_irq, slow} = 4'h0;
    {serial_rx_pin, tx_shift_out} = 2'b11;
    reg_addr = 3'h0;
    wr_data = 8'h00;
    line_on = 4'h0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    t_reset;
    t_ctl;
    t_loop;
    t_status;
    t_inhibit;
    t_baud;
    wrap_up;
  end
endmodule
